// *** rtl/tape_maint_decoder.sv ***
// Tape maintenance command decoder with APB registers and data FIFO
//
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad_depth
        $error("byte_fifo: depth must be a power of two");
    end

    assign o_in_ready = (cnt_ff != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_ff != '0);
    assign push = i_ce && i_in_valid && o_in_ready;
    assign pop = i_ce && o_out_valid && i_out_ready;
    assign o_out_data = mem_ff[rd_ff];

    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem_ff[wr_ff] <= i_in_data;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) begin
                wr_ff <= wr_ff + 1'b1;
            end
            if (pop) begin
                rd_ff <= rd_ff + 1'b1;
            end
            if (push && !pop) begin
                cnt_ff <= cnt_ff + 1'b1;
            end else if (pop && !push) begin
                cnt_ff <= cnt_ff - 1'b1;
            end
        end
    end
endmodule // byte_fifo

module tape_maint_decoder #(
    parameter int MEM_BYTES = 256,
    parameter int FIFO_DEPTH = 4
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic i_test_fail,
    input wire logic [15:0] i_fail_info,
    output logic o_busy,
    output logic o_exec_start,
    output logic [15:0] o_exec_addr,
    output logic o_ext_load,
    output logic o_early_warn,
    output maint_pkg::csb_type o_csb
);
    import maint_pkg::*;

    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_SELF = 7'b0000010,
        ST_LOOP_OUT = 7'b0000100,
        ST_LOOP_IN = 7'b0001000,
        ST_TO_HOST = 7'b0010000,
        ST_FROM_HOST = 7'b0100000,
        ST_DONE = 7'b1000000
    } state_type;

    localparam int MAW = $clog2(MEM_BYTES);

    if (MEM_BYTES < 2 * PARAM_WORDS || (1 << MAW) != MEM_BYTES) begin : g_bad_mem
        $error("tape_maint_decoder: memory size unsupported");
    end

    state_type state_ff;
    logic [15:0] cmd_ff;
    logic [15:0] addr_ff;
    logic [15:0] count_ff;
    logic [15:0] ptr_ff;
    logic [15:0] left_ff;
    logic [7:0] step_ff;
    logic loop_ff;
    logic [15:0] pc_ff;
    logic [7:0] mem_ff [MEM_BYTES];
    logic fault_ff;
    logic src_param_ff;

    logic wr_en;
    logic rd_en;
    logic [7:0] code;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic [7:0] fifo_in_data;
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [7:0] fifo_out_data;
    logic [7:0] param_byte;

    // Classify a code into a state
    function automatic state_type decode(input logic [7:0] c);
        if (c == CODE_LOOPBACK) begin
            return ST_LOOP_OUT;
        end else if (c == CODE_READ_PARAM || c == CODE_READ_MEM) begin
            return ST_TO_HOST;
        end else if (c == CODE_WRITE_MEM) begin
            return ST_FROM_HOST;
        end else if (c == CODE_EXECUTE || c == CODE_EXT_LOAD || c == CODE_EARLY_WARN) begin
            return ST_DONE;
        end
        return ST_SELF;
    endfunction

    // Parameter block byte; pointer entries give memory addresses
    function automatic logic [7:0] param_at(input logic [15:0] idx, input logic [15:0] pc);
        logic [15:0] w;
        w = 16'h0000;
        case (idx[4:1])
            4'h0: w = PARAM_REVISION;
            4'h3: w = 16'(PARAM_WORDS * 2);
            4'h4: w = pc;
            default: w = {12'h000, idx[4:1]} << 4;
        endcase
        return idx[0] ? w[7:0] : w[15:8];
    endfunction

    assign wr_en = i_ce && i_psel && i_penable && i_pwrite;
    assign rd_en = i_psel && i_penable && !i_pwrite;
    assign code = cmd_ff[CODE_MSB:CODE_LSB];
    assign o_pready = 1'b1;
    assign o_pslverr = 1'b0;
    assign o_busy = (state_ff != ST_IDLE);
    assign o_exec_addr = pc_ff;
    assign param_byte = param_at(ptr_ff, pc_ff);

    // Outgoing bytes feed the FIFO; host drains it over APB
    assign fifo_in_valid = (state_ff == ST_TO_HOST && left_ff != 16'h0000)
        || (state_ff == ST_LOOP_OUT);
    assign fifo_in_data = (state_ff == ST_LOOP_OUT) ? LOOP_PATTERN
        : (src_param_ff ? param_byte : mem_ff[ptr_ff[MAW-1:0]]);
    assign fifo_out_ready = i_ce && rd_en && (i_paddr == REG_FIFO_OFF);

    byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fifo_in_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_out_ready),
        .o_out_data(fifo_out_data)
    );

    always_comb begin
        o_prdata = 32'h0000_0000;
        case (i_paddr)
            REG_COMMAND_OFF: o_prdata = {16'h0000, cmd_ff};
            REG_ADDRESS_OFF: o_prdata = {16'h0000, o_csb.address_or_error_word};
            REG_COUNT_OFF: o_prdata = {16'h0000, count_ff};
            REG_STATUS_OFF: o_prdata = {15'h0000, o_busy, o_csb.status};
            REG_CONTROL_OFF: o_prdata = {31'h0, loop_ff};
            REG_FAULT_OFF: o_prdata = {31'h0, fault_ff};
            // An empty FIFO reads as zero rather than a stale byte
            REG_FIFO_OFF: o_prdata = {23'h0, fifo_out_valid,
                (fifo_out_valid ? fifo_out_data : 8'h00)};
            default: o_prdata = 32'h0000_0000;
        endcase
    end

    // Command, address and count words written by software
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cmd_ff <= 16'h0000;
            addr_ff <= 16'h0000;
            count_ff <= 16'h0000;
            loop_ff <= 1'b0;
        end else if (wr_en && state_ff == ST_IDLE) begin
            case (i_paddr)
                REG_COMMAND_OFF: cmd_ff <= i_pwdata[15:0];
                REG_ADDRESS_OFF: addr_ff <= i_pwdata[15:0];
                REG_COUNT_OFF: count_ff <= i_pwdata[15:0];
                REG_CONTROL_OFF: loop_ff <= i_pwdata[CTRL_LOOP_BIT];
                default: loop_ff <= loop_ff;
            endcase
        end
    end

    // Program counter entry is writable through its pointer location
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            pc_ff <= 16'h0000;
        end else if (wr_en && state_ff == ST_IDLE && i_paddr == REG_PARAM_OFF) begin
            pc_ff <= i_pwdata[15:0];
        end
    end

    // Peripheral memory bytes
    always_ff @(posedge i_core_clk) begin
        if (i_ce && state_ff == ST_FROM_HOST && left_ff != 16'h0000 && wr_en
            && i_paddr == REG_FIFO_OFF) begin
            mem_ff[ptr_ff[MAW-1:0]] <= i_pwdata[7:0];
        end
    end

    // Command sequencer
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_ff <= ST_IDLE;
            ptr_ff <= 16'h0000;
            left_ff <= 16'h0000;
            step_ff <= 8'h00;
            fault_ff <= 1'b0;
            src_param_ff <= 1'b0;
            o_csb <= '{done: 1'b0, status: STATUS_RESET, address_or_error_word: 16'h0000};
            o_exec_start <= 1'b0;
            o_ext_load <= 1'b0;
            o_early_warn <= 1'b0;
        end else if (i_ce) begin
            o_exec_start <= 1'b0;
            o_ext_load <= 1'b0;
            o_early_warn <= 1'b0;
            o_csb.done <= 1'b0;
            case (state_ff)
                ST_IDLE: begin
                    if (wr_en && i_paddr == REG_COMMAND_OFF) begin
                        state_ff <= decode(i_pwdata[CODE_MSB:CODE_LSB]);
                        ptr_ff <= (i_pwdata[CODE_MSB:CODE_LSB] == CODE_READ_PARAM)
                            ? 16'h0000 : addr_ff;
                        left_ff <= (i_pwdata[CODE_MSB:CODE_LSB] == CODE_READ_PARAM)
                            ? 16'(PARAM_WORDS * 2) : count_ff;
                        src_param_ff <= (i_pwdata[CODE_MSB:CODE_LSB] == CODE_READ_PARAM);
                        step_ff <= (i_pwdata[CODE_MSB:CODE_LSB] >= CODE_TAPE_ALL
                            && i_pwdata[CODE_MSB:CODE_LSB] <= CODE_TAPE_LAST)
                            ? TAPE_TEST_STEPS : SELF_TEST_STEPS;
                        fault_ff <= 1'b0;
                    end
                end
                ST_SELF: begin
                    if (i_test_fail) begin
                        fault_ff <= 1'b1;
                        o_csb.status <= STATUS_FAIL;
                        o_csb.address_or_error_word <= i_fail_info;
                        o_csb.done <= 1'b1;
                        state_ff <= ST_IDLE;
                    end else if (step_ff <= 8'h01) begin
                        if (loop_ff) begin
                            step_ff <= SELF_TEST_STEPS;
                        end else begin
                            state_ff <= ST_DONE;
                        end
                    end else begin
                        step_ff <= step_ff - 8'h01;
                    end
                end
                ST_LOOP_OUT: begin
                    if (fifo_in_ready) begin
                        state_ff <= ST_LOOP_IN;
                    end
                end
                ST_LOOP_IN: begin
                    if (wr_en && i_paddr == REG_FIFO_OFF) begin
                        if (i_pwdata[7:0] != LOOP_PATTERN) begin
                            o_csb.status <= STATUS_FAIL;
                            o_csb.address_or_error_word <= {CODE_LOOPBACK, i_pwdata[7:0]};
                            o_csb.done <= 1'b1;
                            state_ff <= ST_IDLE;
                        end else begin
                            state_ff <= ST_DONE;
                        end
                    end
                end
                ST_TO_HOST: begin
                    if (left_ff == 16'h0000) begin
                        state_ff <= ST_DONE;
                    end else if (fifo_in_ready) begin
                        ptr_ff <= ptr_ff + 16'h0001;
                        left_ff <= left_ff - 16'h0001;
                    end
                end
                ST_FROM_HOST: begin
                    if (left_ff == 16'h0000) begin
                        state_ff <= ST_DONE;
                    end else if (wr_en && i_paddr == REG_FIFO_OFF) begin
                        ptr_ff <= ptr_ff + 16'h0001;
                        left_ff <= left_ff - 16'h0001;
                    end
                end
                ST_DONE: begin
                    o_exec_start <= (code == CODE_EXECUTE);
                    o_ext_load <= (code == CODE_EXT_LOAD);
                    o_early_warn <= (code == CODE_EARLY_WARN);
                    o_csb.status <= STATUS_OK;
                    o_csb.address_or_error_word <= addr_ff;
                    o_csb.done <= 1'b1;
                    state_ff <= ST_IDLE;
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    property p_fail_status;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_ce && state_ff == ST_SELF && i_test_fail) |=> (o_csb.done && o_csb.status[7:0] == 8'hff
            && o_csb.address_or_error_word == $past(i_fail_info));
    endproperty
    a_fail_status: assert property (p_fail_status) else $error("fail status wrong");

    property p_ok_status;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_ce && state_ff == ST_DONE) |=> (o_csb.done && o_csb.status == STATUS_OK && state_ff == ST_IDLE);
    endproperty
    a_ok_status: assert property (p_ok_status) else $error("completion status wrong");

    property p_exec;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        o_exec_start |-> (code == CODE_EXECUTE && o_exec_addr == pc_ff);
    endproperty
    a_exec: assert property (p_exec) else $error("execute strobe wrong");

    property p_special;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (o_ext_load |-> code == CODE_EXT_LOAD) and (o_early_warn |-> code == CODE_EARLY_WARN);
    endproperty
    a_special: assert property (p_special) else $error("special command wrong");

    property p_param_len;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_ce && state_ff == ST_IDLE && wr_en && i_paddr == REG_COMMAND_OFF
            && i_pwdata[CODE_MSB:CODE_LSB] == CODE_READ_PARAM) |=> (left_ff == 16'd24);
    endproperty
    a_param_len: assert property (p_param_len) else $error("parameter length wrong");

    property p_unassigned;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (i_ce && state_ff == ST_IDLE && wr_en && i_paddr == REG_COMMAND_OFF
            && i_pwdata[CODE_MSB:CODE_LSB] inside {[8'h2b:8'h3a], [8'h25:8'h28], [8'h00:8'h1f]})
            |=> (state_ff == ST_SELF && step_ff == SELF_TEST_STEPS);
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("self-test not selected");

    property p_loop_pattern;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (state_ff == ST_LOOP_OUT) |-> (fifo_in_valid && fifo_in_data == LOOP_PATTERN);
    endproperty
    a_loop_pattern: assert property (p_loop_pattern) else $error("loop data wrong");

    property p_revision;
        @(posedge i_core_clk) disable iff (!i_rst_b)
        (state_ff == ST_TO_HOST && src_param_ff && ptr_ff == 16'h0000)
            |-> (fifo_in_data == PARAM_REVISION[15:8]);
    endproperty
    a_revision: assert property (p_revision) else $error("revision byte wrong");

endmodule // tape_maint_decoder

// *** shared/maint_pkg.sv ***
// Shared constants and carriers for the tape maintenance command decoder
package maint_pkg;

    // APB register byte offsets
    localparam logic [7:0] REG_COMMAND_OFF = 8'h00;
    localparam logic [7:0] REG_ADDRESS_OFF = 8'h04;
    localparam logic [7:0] REG_COUNT_OFF = 8'h08;
    localparam logic [7:0] REG_STATUS_OFF = 8'h0c;
    localparam logic [7:0] REG_CONTROL_OFF = 8'h10;
    localparam logic [7:0] REG_FAULT_OFF = 8'h14;
    localparam logic [7:0] REG_PARAM_OFF = 8'h18;
    localparam logic [7:0] REG_FIFO_OFF = 8'h1c;

    // Field positions
    localparam int CODE_MSB = 15;
    localparam int CODE_LSB = 8;
    localparam int CTRL_LOOP_BIT = 0;

    // Test codes
    localparam logic [7:0] CODE_SELF_LAST = 8'h1f;
    localparam logic [7:0] CODE_TAPE_ALL = 8'h20;
    localparam logic [7:0] CODE_TAPE_LAST = 8'h24;
    localparam logic [7:0] CODE_EXT_LOAD = 8'h29;
    localparam logic [7:0] CODE_EARLY_WARN = 8'h2a;
    localparam logic [7:0] CODE_SELF2_FIRST = 8'h2b;
    localparam logic [7:0] CODE_SELF2_LAST = 8'h3a;
    localparam logic [7:0] CODE_LOOPBACK = 8'h3b;
    localparam logic [7:0] CODE_READ_PARAM = 8'h3c;
    localparam logic [7:0] CODE_EXECUTE = 8'h3d;
    localparam logic [7:0] CODE_WRITE_MEM = 8'h3e;
    localparam logic [7:0] CODE_READ_MEM = 8'h3f;

    // Completion status values
    localparam logic [15:0] STATUS_OK = 16'h8000;
    localparam logic [15:0] STATUS_FAIL = 16'h82ff;
    localparam logic [15:0] STATUS_RESET = 16'h0000;

    // Parameter block
    localparam int PARAM_WORDS = 12;
    localparam logic [15:0] PARAM_REVISION = 16'h4131; // Arbitrary revision text
    localparam int PARAM_PC_INDEX = 4;
    localparam logic [7:0] LOOP_PATTERN = 8'ha5;

    // Step counts for self-test phases
    localparam logic [7:0] SELF_TEST_STEPS = 8'h09;
    localparam logic [7:0] TAPE_TEST_STEPS = 8'h05;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } byte_beat_type;

    typedef struct packed {
        logic done;
        logic [15:0] status;
        logic [15:0] address_or_error_word;
    } csb_type;

endpackage

// *** sim/tape_hw_model.sv ***
// Tape hardware stand-in: fails self-tests on request and counts load, warn and execute pulses
`timescale 1ns/10ps
module tape_hw_model (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_busy,
    input wire logic i_fail_req,
    input wire logic [15:0] i_fail_code,
    input wire logic i_ext_load,
    input wire logic i_early_warn,
    input wire logic i_exec_start,
    output logic o_test_fail,
    output logic [15:0] o_fail_info,
    output logic [7:0] o_load_cnt,
    output logic [7:0] o_warn_cnt,
    output logic [7:0] o_exec_cnt
);
    // A fault is only flagged while a command runs; idle info lines carry junk
    assign o_test_fail = i_fail_req & i_busy;
    assign o_fail_info = o_test_fail ? i_fail_code : ~i_fail_code;

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_load_cnt <= 8'h00;
            o_warn_cnt <= 8'h00;
            o_exec_cnt <= 8'h00;
        end else begin
            o_load_cnt <= o_load_cnt + {7'h00, i_ext_load};
            o_warn_cnt <= o_warn_cnt + {7'h00, i_early_warn};
            o_exec_cnt <= o_exec_cnt + {7'h00, i_exec_start};
        end
    end
endmodule // tape_hw_model

// *** sim/tape_maintenance_command_decoder_tb.sv ***
// Self-checking bench for the tape maintenance command decoder
`timescale 1ns/10ps
module tape_maintenance_command_decoder_tb;
    import maint_pkg::*;
    logic core_clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, fail_req = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, q;
    logic pready, pslverr, busy, exec_start, ext_load, early_warn, test_fail;
    logic [15:0] exec_addr, fail_info, fail_code = 16'h0000;
    logic [7:0] load_cnt, warn_cnt, exec_cnt, b;
    csb_type control_status_block;
    int n_fail = 0;
    int n_tests = 0;
    logic [7:0] codes [13] = '{8'h00, 8'h1f, 8'h2b, 8'h3a, 8'h25, 8'h28, 8'h40, 8'hff,
        8'h20, 8'h21, 8'h22, 8'h23, 8'h24};

    always #5 core_clk = ~core_clk;

    tape_maint_decoder i_dut (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_ce(1'b1),
        .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_test_fail(test_fail), .i_fail_info(fail_info), .o_busy(busy),
        .o_exec_start(exec_start), .o_exec_addr(exec_addr), .o_ext_load(ext_load),
        .o_early_warn(early_warn), .o_csb(control_status_block));

    tape_hw_model i_hw (.i_core_clk(core_clk), .i_rst_b(rst_b), .i_busy(busy),
        .i_fail_req(fail_req), .i_fail_code(fail_code), .i_ext_load(ext_load),
        .i_early_warn(early_warn), .i_exec_start(exec_start), .o_test_fail(test_fail),
        .o_fail_info(fail_info), .o_load_cnt(load_cnt), .o_warn_cnt(warn_cnt),
        .o_exec_cnt(exec_cnt));

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic give_up();
        n_fail++;
        $display("timeout while waiting");
        final_report();
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Setup, then access held until pready is seen high at a rising edge
    task automatic apb(input logic is_wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= is_wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
            if (n > 50) give_up();
        end while (pready !== 1'b1);
        q = prdata;
        check("pslverr", {31'h0, pslverr}, 32'h0);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        apb(1'b0, a, 32'h0);
        check(name, q, exp);
    endtask

    task automatic pop(output logic [7:0] v);
        int n;
        n = 0;
        do begin
            apb(1'b0, REG_FIFO_OFF, 32'h0);
            n++;
            if (n > 40) give_up();
        end while (q[8] !== 1'b1);
        v = q[7:0];
    endtask

    task automatic wait_for(input bit idle);
        int n;
        n = 0;
        do begin
            @(negedge core_clk);
            n++;
            if (n > 500) give_up();
        end while (idle ? busy !== 1'b0 : control_status_block.done !== 1'b1);
    endtask

    task automatic cmd(input logic [7:0] code);
        wr(REG_COMMAND_OFF, {16'h0, code, 8'h00});
    endtask

    task automatic run_cmd(input logic [7:0] code, input logic [15:0] st, input string name);
        cmd(code);
        @(negedge core_clk);
        check("busy", {31'h0, busy}, 32'h1);
        wait_for(1'b0);
        check(name, {16'h0, control_status_block.status}, {16'h0, st});
    endtask

    function automatic logic [7:0] pblk(input int i);
        logic [15:0] w;
        // Inhibit flag entry holds the block length; PC entry holds the value written
        case (i / 2)
            0: w = PARAM_REVISION;
            3: w = 16'(PARAM_WORDS * 2);
            PARAM_PC_INDEX: w = 16'h1234;
            default: w = 16'((i / 2) << 4);
        endcase
        return (i % 2 == 0) ? w[15:8] : w[7:0];
    endfunction

    initial begin
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        rd(REG_STATUS_OFF, {16'h0, STATUS_RESET}, "status_at_reset");
        rd(8'h20, 32'h0, "unmapped");
        foreach (codes[i]) begin
            run_cmd(codes[i], STATUS_OK, "self_test");
        end
        @(posedge core_clk);
        fail_code <= 16'h0307;
        fail_req <= 1'b1;
        run_cmd(8'h00, STATUS_FAIL, "fail_status");
        check("fail_low", {24'h0, control_status_block.status[7:0]}, 32'hff);
        check("err_word", {16'h0, control_status_block.address_or_error_word}, 32'h0307);
        rd(REG_FAULT_OFF, 32'h1, "fault_flag");
        @(posedge core_clk);
        fail_req <= 1'b0;
        cmd(CODE_EXT_LOAD);
        wait_for(1'b1);
        cmd(CODE_EARLY_WARN);
        wait_for(1'b1);
        @(negedge core_clk);
        check("ext_load", {24'h0, load_cnt}, 32'h1);
        check("early_warn", {24'h0, warn_cnt}, 32'h1);
        wr(REG_PARAM_OFF, 32'h1234);
        rd(REG_PARAM_OFF, 32'h0, "pc_read");
        cmd(CODE_EXECUTE);
        wait_for(1'b1);
        @(negedge core_clk);
        check("exec_start", {24'h0, exec_cnt}, 32'h1);
        check("exec_addr", {16'h0, exec_addr}, 32'h1234);
        // Let the FIFO fill and stall before draining the block
        cmd(CODE_READ_PARAM);
        repeat (12) @(posedge core_clk);
        for (int i = 0; i < 2 * PARAM_WORDS; i++) begin
            pop(b);
            check("param", {24'h0, b}, {24'h0, pblk(i)});
        end
        wait_for(1'b1);
        check("param_done", {16'h0, control_status_block.status}, {16'h0, STATUS_OK});
        rd(REG_FIFO_OFF, 32'h0, "fifo_empty");
        // Pointed-to location 0x10 is written and read back
        wr(REG_ADDRESS_OFF, 32'h10);
        wr(REG_COUNT_OFF, 32'h6);
        cmd(CODE_WRITE_MEM);
        for (int i = 0; i < 6; i++) begin
            wr(REG_FIFO_OFF, 32'h30 + i);
        end
        wait_for(1'b0);
        check("wmem_done", {16'h0, control_status_block.status}, {16'h0, STATUS_OK});
        cmd(CODE_READ_MEM);
        repeat (12) @(posedge core_clk);
        for (int i = 0; i < 6; i++) begin
            pop(b);
            check("rmem", {24'h0, b}, 32'h30 + i);
        end
        wait_for(1'b1);
        for (int k = 0; k < 2; k++) begin
            cmd(CODE_LOOPBACK);
            pop(b);
            check("loop_data", {24'h0, b}, {24'h0, LOOP_PATTERN});
            wr(REG_FIFO_OFF, {24'h0, (k == 0) ? LOOP_PATTERN : ~LOOP_PATTERN});
            wait_for(1'b0);
            check("loop_status", {16'h0, control_status_block.status}, (k == 0) ? 32'h8000 : 32'h82ff);
        end
        wr(REG_CONTROL_OFF, 32'h1);
        cmd(8'h00);
        repeat (100) @(posedge core_clk);
        @(negedge core_clk);
        check("loop_busy", {31'h0, busy}, 32'h1);
        @(posedge core_clk);
        rst_b <= 1'b0;
        @(negedge core_clk);
        check("reset_busy", {31'h0, busy}, 32'h0);
        check("reset_status", {16'h0, control_status_block.status}, {16'h0, STATUS_RESET});
        @(posedge core_clk);
        rst_b <= 1'b1;
        rd(REG_CONTROL_OFF, 32'h0, "loop_cleared");
        final_report();
    end
endmodule // tape_maintenance_command_decoder_tb
